// ### src/ris_irq_status.sv
// Interrupt status register and interrupt line of the reader framing core
// Operation
// R1 - Set transmit bit at transmit start; raise interrupt only after transmit ends.
// R2 - Set receive-start bit on start-of-frame; raise interrupt when reception ends.
// R3 - Set FIFO bit when fill level crosses programmed high or low threshold.
// R4 - Flag receive CRC error only while receive CRC check is enabled.
// R5 - Set parity fault bit on parity error in type A frames.
// R6 - Set framing fault bit on byte framing or end-of-frame error.
// R7 - Set collision bit on collision reported by the subcarrier counter.
// R8 - In vicinity mode set no-response bit when reply wait time expires.
// R9 - Host read of status register clears all bits and interrupt line.
// R10 - Decoder off while transmitting; only FIFO and transmit bits change.
// R11 - While receiving only receive-start bit changes, plus fault bits in the cycle that ends reception; no immediate interrupt.
// R12 - Interrupt raised at end of each transmit and receive phase.
// R13 - Error, FIFO and no-response interrupts gated by mask enables with reset values.
// R14 - Interrupt stays high until host completes a status read.
`timescale 1ns/100ps
`default_nettype none
module ris_irq_status
    import ris_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire ris_event_s event_i,
    input wire logic rx_crc_off_i,
    input wire logic vicinity_mode_i,
    input wire logic [5:0] irq_enable_i,
    input wire logic rd_strobe_i,
    input wire logic rd_done_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic irq_o,
    output logic decoder_en_o
);
    ris_phase_e phase;
    ris_phase_e next_phase;
    logic decoder_en;
    logic next_decoder_en;
    logic [7:0] status;
    logic [7:0] next_status;
    logic irq;
    logic next_irq;
    logic [7:0] rd_data;
    logic [7:0] next_rd_data;
    logic err_window;
    logic [7:0] set_bits;
    logic [5:0] src_hit;
    logic raise;
    logic rd_hit;
    logic clear;

    always_comb begin
        next_phase = phase;
        case (phase)
            PH_IDLE: begin
                if (event_i.tx_start) begin
                    next_phase = PH_TX;
                end else if (event_i.rx_sof) begin
                    next_phase = PH_RX;
                end
            end
            PH_TX: begin
                if (event_i.tx_end) begin
                    next_phase = PH_IDLE;
                end
            end
            PH_RX: begin
                if (event_i.rx_end) begin
                    next_phase = PH_IDLE;
                end
            end
            default: begin
                next_phase = PH_IDLE;
            end
        endcase
        // Decoder stays off through transmit so own carrier is not decoded
        next_decoder_en = (next_phase != PH_TX); // R10
    end

    // Phase group: transfer phase and decoder enable
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= PH_IDLE;
            decoder_en <= DECODER_EN_RESET;
        end else begin
            phase <= next_phase;
            decoder_en <= next_decoder_en;
        end
    end

    // Reception faults arrive with end-of-frame, so they are taken while idle
    // and in the cycle that closes reception; inside a frame they are refused
    always_comb begin
        err_window = 1'b0;
        case (phase)
            PH_IDLE: begin
                err_window = 1'b1;
            end
            PH_RX: begin
                err_window = event_i.rx_end; // R11
            end
            default: begin
                err_window = 1'b0;
            end
        endcase
    end

    always_comb begin
        set_bits = 8'h00;
        case (phase)
            PH_IDLE: begin
                set_bits[TX_BIT] = event_i.tx_start; // R1
                // Transmit start wins if both phases start in one cycle
                set_bits[SRX_BIT] = event_i.rx_sof && !event_i.tx_start; // R2
                set_bits[FIFO_BIT] = event_i.fifo_level; // R3
            end
            PH_TX: begin
                // Decoder is off: only the FIFO and transmit bits may move
                set_bits[TX_BIT] = 1'b1; // R1 R10
                set_bits[FIFO_BIT] = event_i.fifo_level; // R3 R10
            end
            PH_RX: begin
                set_bits[SRX_BIT] = 1'b1; // R2 R11
            end
            default: begin
                set_bits = 8'h00;
            end
        endcase
        if (err_window) begin
            set_bits[CRC_BIT] = event_i.crc_fault && !rx_crc_off_i; // R4
            set_bits[PAR_BIT] = event_i.parity_fault; // R5
            set_bits[FRM_BIT] = event_i.framing_fault; // R6
            set_bits[COL_BIT] = event_i.collision; // R7
            // No-response only counts in vicinity mode
            set_bits[NRSP_BIT] = event_i.no_response && vicinity_mode_i; // R8
        end
    end

    // Transmit and receive-start bits are never masked; the other sources are
    always_comb begin
        src_hit[MASK_FIFO] = set_bits[FIFO_BIT] && irq_enable_i[MASK_FIFO]; // R13
        src_hit[MASK_CRC] = set_bits[CRC_BIT] && irq_enable_i[MASK_CRC]; // R13
        src_hit[MASK_PAR] = set_bits[PAR_BIT] && irq_enable_i[MASK_PAR]; // R13
        src_hit[MASK_FRM] = set_bits[FRM_BIT] && irq_enable_i[MASK_FRM]; // R13
        src_hit[MASK_COL] = set_bits[COL_BIT] && irq_enable_i[MASK_COL]; // R13
        src_hit[MASK_NRSP] = set_bits[NRSP_BIT] && irq_enable_i[MASK_NRSP]; // R13
        raise = 1'b0;
        case (phase)
            PH_IDLE: begin
                raise = |src_hit; // R13
            end
            PH_TX: begin
                // A FIFO level interrupt cannot wait for the end of transmit
                raise = event_i.tx_end || src_hit[MASK_FIFO]; // R1 R12
            end
            PH_RX: begin
                // Receive start stays silent until reception ends
                raise = event_i.rx_end; // R2 R11 R12
            end
            default: begin
                raise = 1'b0;
            end
        endcase
    end

    // Strobe and done may share one cycle; the strobe then sees pre-clear status
    assign rd_hit = (rd_addr_i == STATUS_ADDR);
    assign clear = rd_done_i && rd_hit; // R9

    // Status group: set wins so an event in the last read cycle is not lost
    always_comb begin
        next_status = status | set_bits;
        if (clear) begin
            next_status = set_bits; // R9
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            status <= STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // Interrupt group: a level that only a status read takes down
    always_comb begin
        next_irq = irq; // R14
        if (clear) begin
            next_irq = 1'b0; // R9
        end
        if (raise) begin
            next_irq = 1'b1; // R12
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq <= IRQ_RESET;
        end else begin
            irq <= next_irq;
        end
    end

    // Read group: data captured at the strobe and held until the next one
    always_comb begin
        next_rd_data = rd_data;
        if (rd_strobe_i) begin
            if (rd_hit) begin
                next_rd_data = status;
            end else begin
                next_rd_data = UNMAPPED_DATA;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data <= RD_DATA_RESET;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    assign rd_data_o = rd_data;
    assign irq_o = irq;
    assign decoder_en_o = decoder_en;
endmodule
`default_nettype wire

// ### src/ris_pkg.sv
// Package of constants and carriers for the RFID interrupt status logic
package ris_pkg;
    localparam logic [7:0] STATUS_ADDR = 8'h0c;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [5:0] MASK_RESET = 6'h3e;
    localparam logic [7:0] RD_DATA_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam logic IRQ_RESET = 1'b0;
    localparam logic DECODER_EN_RESET = 1'b1;
    localparam int TX_BIT = 7;
    localparam int SRX_BIT = 6;
    localparam int FIFO_BIT = 5;
    localparam int CRC_BIT = 4;
    localparam int PAR_BIT = 3;
    localparam int FRM_BIT = 2;
    localparam int COL_BIT = 1;
    localparam int NRSP_BIT = 0;
    localparam int MASK_FIFO = 5;
    localparam int MASK_CRC = 4;
    localparam int MASK_PAR = 3;
    localparam int MASK_FRM = 2;
    localparam int MASK_COL = 1;
    localparam int MASK_NRSP = 0;

    // Events from the framing core, all one-cycle pulses on mclk_i
    typedef struct packed {
        logic tx_start;
        logic tx_end;
        logic rx_sof;
        logic rx_end;
        logic fifo_level;
        logic crc_fault;
        logic parity_fault;
        logic framing_fault;
        logic collision;
        logic no_response;
    } ris_event_s;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_TX = 3'b010,
        PH_RX = 3'b100
    } ris_phase_e;
endpackage

// ### bench/ris_irq_status_asserts.sv
// Port assertions for the interrupt status logic
`timescale 1ns/100ps
`default_nettype none
module ris_irq_status_asserts
    import ris_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire ris_event_s event_i,
    input wire logic rx_crc_off_i,
    input wire logic rd_strobe_i,
    input wire logic rd_done_i,
    input wire logic [7:0] rd_addr_i,
    input wire logic [7:0] rd_data_o,
    input wire logic irq_o,
    input wire logic decoder_en_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire clr = rd_done_i && rd_addr_i == STATUS_ADDR;
    wire tx = !decoder_en_o;
    property p_hold; irq_o && !clr |=> irq_o; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped");
    property p_clr; clr && event_i == '0 |=> !irq_o; endproperty
    a_clr: assert property (p_clr) else $error("irq not cleared");
    property p_txs; event_i == ris_event_s'(10'h200) && !irq_o |=> !irq_o; endproperty
    a_txs: assert property (p_txs) else $error("irq at tx start");
    property p_txe; tx && event_i.tx_end |=> irq_o && decoder_en_o; endproperty
    a_txe: assert property (p_txe) else $error("no irq at tx end");
    property p_txq; tx && !irq_o && !event_i.fifo_level && !event_i.tx_end |=> !irq_o; endproperty
    a_txq: assert property (p_txq) else $error("irq during tx");
    property p_crc; rx_crc_off_i && !irq_o && event_i == ris_event_s'(10'h010) |=> !irq_o; endproperty
    a_crc: assert property (p_crc) else $error("crc not ignored");
    property p_rdh; !rd_strobe_i |=> $stable(rd_data_o); endproperty
    a_rdh: assert property (p_rdh) else $error("read data moved");
    property p_una; rd_strobe_i && rd_addr_i != STATUS_ADDR |=> rd_data_o == 8'h00; endproperty
    a_una: assert property (p_una) else $error("unmapped not zero");
endmodule
bind ris_irq_status ris_irq_status_asserts ris_irq_status_asserts_inst(.mclk_i, .rst_i, .event_i, .rx_crc_off_i,
    .rd_strobe_i, .rd_done_i, .rd_addr_i, .rd_data_o, .irq_o, .decoder_en_o);
`default_nettype wire

// ### bench/ris_host_model.sv
// Host model that reads registers through the read port
`timescale 1ns/100ps
`default_nettype none
module ris_host_model (
    input wire logic mclk_i,
    input wire logic [7:0] rd_data_i,
    output logic rd_strobe_o,
    output logic rd_done_o,
    output logic [7:0] rd_addr_o
);
    initial begin
        rd_strobe_o = 0;
        rd_done_o = 0;
        rd_addr_o = 8'hff;
    end
    // Strobe and done share one cycle; the strobe still sees pre-clear status
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_i) {rd_strobe_o, rd_done_o, rd_addr_o} = {2'b11, a};
        @(negedge mclk_i) {rd_strobe_o, rd_done_o, rd_addr_o} = {2'b00, ~a};
        d = rd_data_i;
    endtask
endmodule
`default_nettype wire

// ### bench/ris_irq_status_tb.sv
// Testbench for the interrupt status logic
`timescale 1ns/100ps
`default_nettype none
module ris_irq_status_tb
    import ris_pkg::*;
;
    logic mclk_i = 0, rst_i = 1, crc_off = 0, vic = 1, rs, rdn, irq, dec;
    logic [5:0] en = 6'h3f;
    logic [7:0] ad, rdat, d;
    ris_event_s ev = '0;
    int n_mismatch = 0, comparisons = 0, cyc = 0;
    always #4 mclk_i = ~mclk_i;
    ris_irq_status ris_irq_status_inst(.mclk_i(mclk_i), .rst_i(rst_i), .event_i(ev), .rx_crc_off_i(crc_off),
        .vicinity_mode_i(vic), .irq_enable_i(en), .rd_strobe_i(rs), .rd_done_i(rdn), .rd_addr_i(ad),
        .rd_data_o(rdat), .irq_o(irq), .decoder_en_o(dec));
    ris_host_model ris_host_model_inst(.mclk_i(mclk_i), .rd_data_i(rdat), .rd_strobe_o(rs), .rd_done_o(rdn),
        .rd_addr_o(ad));
    task chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_pin(input logic [1:0] g, input logic [1:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t lines got %b exp %b", $time, g, e);
        end
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        ris_host_model_inst.read(a, d);
        chk(d, e);
    endtask
    task pulse(input logic [9:0] e);
        @(negedge mclk_i) ev = ris_event_s'(e);
        @(negedge mclk_i) ev = '0;
    endtask
    task conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude;
        end
    end
    initial begin
        repeat (16) @(negedge mclk_i);
        rst_i = 0;
        chk_pin({irq, dec}, 2'b01);
        rd(STATUS_ADDR, STATUS_RESET);
        pulse(10'h200);
        pulse(10'h01f);
        chk_pin({irq, dec}, 2'b00);
        pulse(10'h020);
        chk_pin({irq, dec}, 2'b10);
        pulse(10'h100);
        chk_pin({irq, dec}, 2'b11);
        rd(STATUS_ADDR, 8'ha0);
        chk_pin({irq, dec}, 2'b01);
        pulse(10'h080);
        pulse(10'h03f);
        chk_pin({irq, dec}, 2'b01);
        pulse(10'h040);
        chk_pin({irq, dec}, 2'b11);
        rd(STATUS_ADDR, 8'h40);
        pulse(10'h080);
        pulse(10'h050);
        chk_pin({irq, dec}, 2'b11);
        rd(STATUS_ADDR, 8'h50);
        $display("phase test done");
        for (int i = 0; i < 6; i++) begin
            pulse(10'h001 << i);
            chk_pin({irq, dec}, 2'b11);
            rd(STATUS_ADDR, 8'h01 << i);
        end
        en = MASK_RESET;
        pulse(10'h001);
        chk_pin({irq, dec}, 2'b01);
        rd(STATUS_ADDR, 8'h01);
        {crc_off, vic, en} = 8'h80;
        pulse(10'h010);
        pulse(10'h035);
        chk_pin({irq, dec}, 2'b01);
        rd(8'h0d, 8'h00);
        rd(STATUS_ADDR, 8'h24);
        $display("event test done");
        pulse(10'h200);
        pulse(10'h100);
        pulse(10'h200);
        chk_pin({irq, dec}, 2'b10);
        @(negedge mclk_i) rst_i = 1;
        @(negedge mclk_i) rst_i = 0;
        chk_pin({irq, dec}, 2'b01);
        rd(STATUS_ADDR, STATUS_RESET);
        $display("reset test done");
        conclude;
    end
endmodule
`default_nettype wire
